// ===== cca_pkg.sv
package cca_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int LEVEL_W = 10;
  localparam int ACC_W = 14;

  // Register map.
  localparam logic [15:0] ADDR_RSSI_WIN = 16'h2223;
  localparam logic [15:0] ADDR_CTRL = 16'h2248;
  localparam logic [15:0] ADDR_THRESH = 16'h2249;
  localparam logic [15:0] ADDR_OFFSET = 16'h224A;
  localparam logic [15:0] ADDR_HYST = 16'h224B;
  localparam logic [15:0] ADDR_STATUS = 16'h224C;
  localparam logic [15:0] ADDR_LEVEL = 16'h224D;

  // Reset values; reserved bits keep these values for good.
  localparam logic [7:0] RST_RSSI_WIN = 8'hE7;
  localparam logic [7:0] RST_CTRL = 8'hC4;
  localparam logic [7:0] RST_THRESH = 8'hB2;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_HYST = 8'hF4;

  // Writable bits of each register.
  localparam logic [7:0] WMASK_RSSI_WIN = 8'h18;
  localparam logic [7:0] WMASK_CTRL = 8'h7B;
  localparam logic [7:0] WMASK_FULL = 8'hFF;
  localparam logic [7:0] WMASK_HYST = 8'h0F;

  // Field positions.
  localparam int RSSI_WIN_LSB = 3;
  localparam int AWS_LSB = 4;
  localparam int FIX_BIT = 3;
  localparam int MD_LSB = 0;
  localparam int HYST_LSB = 0;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_ED_BIT = 1;
  localparam int STS_SEEN_BIT = 2;
  localparam int STS_BLOCK_BIT = 3;

  // Energy is sampled once per microsecond.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SAMPLE_NS = 1000;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);
  localparam logic [2:0] AWS_MAX_SHIFT = 3'h4;

  typedef enum logic [1:0] {
    CCA_MD_ENERGY = 2'b00,
    CCA_MD_CARRIER = 2'b01,
    CCA_MD_FRAME = 2'b10,
    CCA_MD_RSVD = 2'b11
  } cca_method_t;

  typedef struct packed {
    logic carrierDetection;
    logic frameDetection;
  } cca_demod_t;

  function automatic logic signed [LEVEL_W-1:0] cca_sext8(input logic [7:0] v);
    return {{(LEVEL_W-8){v[7]}}, v};
  endfunction : cca_sext8

  // Samples averaged are 2**shift; any code above 3 averages 16 samples.
  function automatic logic [2:0] cca_avg_shift(input logic [2:0] aws);
    return (aws > 3'h3) ? AWS_MAX_SHIFT : aws;
  endfunction : cca_avg_shift

endpackage : cca_pkg

// ===== cca_energy_avg.sv
`timescale 1ns/1ps
module cca_energy_avg
  import cca_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic signed [cca_pkg::LEVEL_W-1:0] energyLevel,
  input wire logic [2:0] avgDuration,
  output logic signed [cca_pkg::LEVEL_W-1:0] avgLevel_ff,
  output logic avgValid_ff
);

  logic [3:0] tick_ff, nxt_tick;
  logic [4:0] idx_ff, nxt_idx;
  logic signed [ACC_W-1:0] acc_ff, nxt_acc;
  logic signed [LEVEL_W-1:0] nxt_avgLevel;
  logic nxt_avgValid;

  always_comb begin
    logic signed [ACC_W-1:0] sum;
    logic [2:0] sh;
    sum = acc_ff + ACC_W'(energyLevel);
    sh = cca_avg_shift(avgDuration);
    nxt_tick = tick_ff + 4'h1;
    nxt_idx = idx_ff;
    nxt_acc = acc_ff;
    nxt_avgLevel = avgLevel_ff;
    nxt_avgValid = 1'b0;
    if (tick_ff == SAMPLE_LAST) begin
      nxt_tick = 4'h0;
      if (idx_ff >= 5'((5'h1 << sh) - 5'h1)) begin
        nxt_avgLevel = LEVEL_W'(sum >>> sh);
        nxt_avgValid = 1'b1;
        nxt_idx = 5'h0;
        nxt_acc = '0;
      end else begin
        nxt_idx = idx_ff + 5'h1;
        nxt_acc = sum;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_ff <= 4'h0;
      idx_ff <= 5'h0;
      acc_ff <= '0;
      avgLevel_ff <= '0;
      avgValid_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
      idx_ff <= nxt_idx;
      acc_ff <= nxt_acc;
      avgLevel_ff <= nxt_avgLevel;
      avgValid_ff <= nxt_avgValid;
    end
  end

endmodule : cca_energy_avg

// ===== cca_busy_decide.sv
`timescale 1ns/1ps
module cca_busy_decide
  import cca_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic signed [cca_pkg::LEVEL_W-1:0] avgLevel,
  input wire logic avgValid,
  input wire logic [7:0] busyThreshold,
  input wire logic [3:0] idleHysteresis,
  output logic edBusy_ff
);

  logic nxt_edBusy;

  always_comb begin
    logic signed [LEVEL_W-1:0] thr;
    logic signed [LEVEL_W-1:0] hyst;
    thr = cca_sext8(busyThreshold);
    hyst = {{(LEVEL_W-4){idleHysteresis[3]}}, idleHysteresis};
    nxt_edBusy = edBusy_ff;
    if (!enable) begin
      // Other methods ignore the threshold; state restarts idle on return.
      nxt_edBusy = 1'b0;
    end else if (avgValid) begin
      if (!edBusy_ff && avgLevel >= thr) begin
        nxt_edBusy = 1'b1;
      end else if (edBusy_ff && avgLevel < LEVEL_W'(thr - hyst)) begin
        nxt_edBusy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edBusy_ff <= 1'b0;
    end else begin
      edBusy_ff <= nxt_edBusy;
    end
  end

endmodule : cca_busy_decide

// ===== cca_core.sv
`timescale 1ns/1ps
module cca_core
  import cca_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [cca_pkg::ADDR_W-1:0] regAddr,
  input wire logic [cca_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [cca_pkg::DATA_W-1:0] regRdData_ff,
  input wire logic [7:0] frontEndGain,
  input wire cca_pkg::cca_demod_t demod,
  input wire logic txRequest,
  output logic txStart_ff,
  output logic channelBusy_ff,
  output logic [1:0] rssiAverageWindow_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [7:0] rssiWinReg_ff, nxt_rssiWinReg;
  logic [7:0] ctrlReg_ff, nxt_ctrlReg;
  logic [7:0] threshReg_ff, nxt_threshReg;
  logic [7:0] offsetReg_ff, nxt_offsetReg;
  logic [7:0] hystReg_ff, nxt_hystReg;

  function automatic logic [7:0] maskedWrite(input logic [7:0] old, input logic [7:0] wd,
                                             input logic [7:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction : maskedWrite

  always_comb begin
    nxt_rssiWinReg = rssiWinReg_ff;
    nxt_ctrlReg = ctrlReg_ff;
    nxt_threshReg = threshReg_ff;
    nxt_offsetReg = offsetReg_ff;
    nxt_hystReg = hystReg_ff;
    if (regWr) begin
      unique case (regAddr)
        ADDR_RSSI_WIN: nxt_rssiWinReg = maskedWrite(rssiWinReg_ff, regWrData, WMASK_RSSI_WIN);
        ADDR_CTRL: nxt_ctrlReg = maskedWrite(ctrlReg_ff, regWrData, WMASK_CTRL);
        ADDR_THRESH: nxt_threshReg = regWrData;
        ADDR_OFFSET: nxt_offsetReg = regWrData;
        ADDR_HYST: nxt_hystReg = maskedWrite(hystReg_ff, regWrData, WMASK_HYST);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rssiWinReg_ff <= RST_RSSI_WIN;
      ctrlReg_ff <= RST_CTRL;
      threshReg_ff <= RST_THRESH;
      offsetReg_ff <= RST_OFFSET;
      hystReg_ff <= RST_HYST;
    end else begin
      rssiWinReg_ff <= nxt_rssiWinReg;
      ctrlReg_ff <= nxt_ctrlReg;
      threshReg_ff <= nxt_threshReg;
      offsetReg_ff <= nxt_offsetReg;
      hystReg_ff <= nxt_hystReg;
    end
  end

  logic [2:0] avgDuration;
  logic idleLock;
  cca_method_t method;
  logic [3:0] idleHysteresis;

  assign avgDuration = ctrlReg_ff[AWS_LSB +: 3];
  assign idleLock = ctrlReg_ff[FIX_BIT];
  assign method = cca_method_t'(ctrlReg_ff[MD_LSB +: 2]);
  assign idleHysteresis = hystReg_ff[HYST_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Energy level, averaging and the energy decision.

  logic signed [LEVEL_W-1:0] energyLevel;
  logic signed [LEVEL_W-1:0] avgLevel;
  logic avgValid;
  logic edBusy;

  // The gain is an unsigned step count, so it is zero-extended, while the offset is signed.
  assign energyLevel = cca_sext8(offsetReg_ff) - LEVEL_W'(frontEndGain);

  cca_energy_avg uAvg (
    .clk(clk),
    .arst_n(arst_n),
    .energyLevel(energyLevel),
    .avgDuration(avgDuration),
    .avgLevel_ff(avgLevel),
    .avgValid_ff(avgValid)
  );

  cca_busy_decide uDecide (
    .clk(clk),
    .arst_n(arst_n),
    .enable(method == CCA_MD_ENERGY),
    .avgLevel(avgLevel),
    .avgValid(avgValid),
    .busyThreshold(threshReg_ff),
    .idleHysteresis(idleHysteresis),
    .edBusy_ff(edBusy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel state, transmit gating and sticky status.

  logic nxt_channelBusy;
  logic nxt_txStart;
  logic busySeen_ff, nxt_busySeen;
  logic txBlocked_ff, nxt_txBlocked;
  logic [1:0] nxt_rssiAverageWindow;
  logic rawBusy;
  logic stsClear;

  always_comb begin
    unique case (method)
      CCA_MD_ENERGY: rawBusy = edBusy;
      CCA_MD_CARRIER: rawBusy = demod.carrierDetection;
      CCA_MD_FRAME: rawBusy = demod.frameDetection;
      CCA_MD_RSVD: rawBusy = 1'b0;
    endcase
  end

  assign stsClear = regWr && (regAddr == ADDR_STATUS);

  always_comb begin
    nxt_channelBusy = rawBusy && !idleLock;
    // The live state gates the start so a request never slips past a fresh busy.
    nxt_txStart = txRequest && !channelBusy_ff && !nxt_channelBusy && !txStart_ff;
    // Hardware set wins over a software clear in the same cycle.
    nxt_busySeen = busySeen_ff;
    if (stsClear && regWrData[STS_SEEN_BIT]) begin
      nxt_busySeen = 1'b0;
    end
    if (nxt_channelBusy) begin
      nxt_busySeen = 1'b1;
    end
    nxt_txBlocked = txBlocked_ff;
    if (stsClear && regWrData[STS_BLOCK_BIT]) begin
      nxt_txBlocked = 1'b0;
    end
    if (txRequest && (channelBusy_ff || nxt_channelBusy)) begin
      nxt_txBlocked = 1'b1;
    end
    nxt_rssiAverageWindow = rssiWinReg_ff[RSSI_WIN_LSB +: 2];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      channelBusy_ff <= 1'b0;
      txStart_ff <= 1'b0;
      busySeen_ff <= 1'b0;
      txBlocked_ff <= 1'b0;
      rssiAverageWindow_ff <= 2'b00;
    end else begin
      channelBusy_ff <= nxt_channelBusy;
      txStart_ff <= nxt_txStart;
      busySeen_ff <= nxt_busySeen;
      txBlocked_ff <= nxt_txBlocked;
      rssiAverageWindow_ff <= nxt_rssiAverageWindow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; data stand only in the cycle after the strobe.

  logic [7:0] nxt_regRdData;
  logic [7:0] statusWord;

  always_comb begin
    statusWord = 8'h00;
    statusWord[STS_BUSY_BIT] = channelBusy_ff;
    statusWord[STS_ED_BIT] = edBusy;
    statusWord[STS_SEEN_BIT] = busySeen_ff;
    statusWord[STS_BLOCK_BIT] = txBlocked_ff;
    nxt_regRdData = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        ADDR_RSSI_WIN: nxt_regRdData = rssiWinReg_ff;
        ADDR_CTRL: nxt_regRdData = ctrlReg_ff;
        ADDR_THRESH: nxt_regRdData = threshReg_ff;
        ADDR_OFFSET: nxt_regRdData = offsetReg_ff;
        ADDR_HYST: nxt_regRdData = hystReg_ff;
        ADDR_STATUS: nxt_regRdData = statusWord;
        // Averaged level is truncated to the low byte, not saturated; it is a debug view only.
        ADDR_LEVEL: nxt_regRdData = avgLevel[7:0];
        default: nxt_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_ff <= 8'h00;
    end else begin
      regRdData_ff <= nxt_regRdData;
    end
  end

endmodule : cca_core

// ===== cca_checker.sv
`timescale 1ns/1ps
module cca_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData_ff,
  input wire logic [7:0] frontEndGain,
  input wire cca_pkg::cca_demod_t demod,
  input wire logic txRequest,
  input wire logic txStart_ff,
  input wire logic channelBusy_ff,
  input wire logic [1:0] rssiAverageWindow_ff
);
  import cca_pkg::*;
  logic ctrlWr;
  logic rssiWr;
  logic lock_ff;
  logic nxt_lock;
  logic [1:0] method_ff;
  logic [1:0] nxt_method;
  assign ctrlWr = regWr && regAddr == ADDR_CTRL;
  assign rssiWr = regWr && regAddr == ADDR_RSSI_WIN;
  // Shadow of the control fields, kept from the bus writes alone.
  always_comb begin
    nxt_lock = ctrlWr ? regWrData[FIX_BIT] : lock_ff;
    nxt_method = ctrlWr ? regWrData[1:0] : method_ff;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_ff <= 1'h0;
      method_ff <= 2'h0;
    end else begin
      lock_ff <= nxt_lock;
      method_ff <= nxt_method;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // A control write in the same cycle changes the mode, so it is left out.
  lock_idle_a: assert property (lock_ff && !ctrlWr |=> !channelBusy_ff)
    else $error("busy while idle lock set");
  tx_not_busy_a: assert property (txStart_ff |-> !$past(channelBusy_ff))
    else $error("start while busy");
  tx_pulse_a: assert property (txStart_ff |=> !txStart_ff)
    else $error("start longer than one cycle");
  tx_cause_a: assert property (txStart_ff |-> $past(txRequest))
    else $error("start without request");
  carrier_busy_a: assert property (
    method_ff == CCA_MD_CARRIER && !lock_ff && !ctrlWr
    |=> channelBusy_ff == $past(demod.carrierDetection))
    else $error("carrier mode busy wrong");
  frame_busy_a: assert property (
    method_ff == CCA_MD_FRAME && !lock_ff && !ctrlWr
    |=> channelBusy_ff == $past(demod.frameDetection))
    else $error("frame mode busy wrong");
  reserved_idle_a: assert property (method_ff == CCA_MD_RSVD && !ctrlWr |=> !channelBusy_ff)
    else $error("reserved mode busy");
  window_copy_a: assert property (
    rssiWr ##1 !rssiWr |=> rssiAverageWindow_ff == $past(regWrData[4:3], 2))
    else $error("window field not copied");
endmodule : cca_checker

// ===== cca_partner.sv
`timescale 1ns/1ps
module cca_partner (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] gainSet,
  input wire logic carrierSet,
  input wire logic frameSet,
  input wire logic sendReq,
  input wire logic txStart_ff,
  output logic [7:0] frontEndGain,
  output cca_pkg::cca_demod_t demod,
  output logic txRequest_ff
);
  import cca_pkg::*;
  logic nxt_txRequest;
  assign frontEndGain = gainSet;
  assign demod.carrierDetection = carrierSet;
  assign demod.frameDetection = frameSet;
  // The sender keeps asking until a start is granted, then drops at once.
  always_comb begin
    nxt_txRequest = txStart_ff ? 1'h0 : (sendReq | txRequest_ff);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txRequest_ff <= 1'h0;
    end else begin
      txRequest_ff <= nxt_txRequest;
    end
  end
endmodule : cca_partner

// ===== cca_core_tb.sv
`timescale 1ns/1ps
module cca_core_tb;
  import cca_pkg::*;
  logic clk;
  logic arst_n;
  logic [15:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData_ff;
  logic [7:0] gainSet;
  logic carrierSet;
  logic frameSet;
  logic sendReq;
  logic [7:0] frontEndGain;
  cca_demod_t demod;
  logic txRequest;
  logic txStart_ff;
  logic channelBusy_ff;
  logic [1:0] rssiAverageWindow_ff;
  int failCount = 0;
  int testsRun = 0;
  int startCnt = 0;
  cca_core cca_core_inst (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff),
    .frontEndGain(frontEndGain), .demod(demod), .txRequest(txRequest),
    .txStart_ff(txStart_ff), .channelBusy_ff(channelBusy_ff),
    .rssiAverageWindow_ff(rssiAverageWindow_ff));
  cca_partner cca_partner_inst (.clk(clk), .arst_n(arst_n), .gainSet(gainSet),
    .carrierSet(carrierSet), .frameSet(frameSet), .sendReq(sendReq),
    .txStart_ff(txStart_ff), .frontEndGain(frontEndGain), .demod(demod),
    .txRequest_ff(txRequest));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (txStart_ff === 1'h1) startCnt++;
  ////////////////////////////////////////////////////////////////
  task automatic reportAndStop();
    if (failCount == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : reportAndStop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
    @(posedge clk);
  endtask : wr
  // Outputs are read at the edge, so the value seen is the one settled before it.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    @(posedge clk);
    d = regRdData_ff;
  endtask : rd
  task automatic waitBusy(input logic b, input int maxc, output int n);
    n = 0;
    while (channelBusy_ff !== b && n < maxc) begin
      @(posedge clk);
      n++;
    end
  endtask : waitBusy
  task automatic settle(input int c, input logic [7:0] exp);
    repeat (c) @(posedge clk);
    chk(8'(channelBusy_ff), exp);
  endtask : settle
  task automatic pulseSend();
    sendReq <= 1'h1;
    @(posedge clk);
    sendReq <= 1'h0;
    @(posedge clk);
  endtask : pulseSend
  ////////////////////////////////////////////////////////////////
  task automatic testRegs();
    logic [15:0] adr [5];
    logic [7:0] rv [5];
    logic [7:0] msk [5];
    logic [7:0] d;
    adr = '{ADDR_RSSI_WIN, ADDR_CTRL, ADDR_THRESH, ADDR_OFFSET, ADDR_HYST};
    rv = '{RST_RSSI_WIN, RST_CTRL, RST_THRESH, RST_OFFSET, RST_HYST};
    msk = '{WMASK_RSSI_WIN, WMASK_CTRL, WMASK_FULL, WMASK_FULL, WMASK_HYST};
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], d);
      chk(d, rv[i]);
      wr(adr[i], 8'h00);
      rd(adr[i], d);
      chk(d, rv[i] & ~msk[i]);
      wr(adr[i], 8'hFF);
      rd(adr[i], d);
      chk(d, rv[i] | msk[i]);
      wr(adr[i], rv[i]);
    end
    wr(ADDR_RSSI_WIN, 8'h10);
    repeat (2) @(posedge clk);
    chk(8'(rssiAverageWindow_ff), 8'h02);
    wr(16'h2250, 8'h5A);
    rd(16'h2250, d);
    chk(d, 8'h00);
  endtask : testRegs
  task automatic testDetect();
    int n;
    logic [7:0] d;
    gainSet <= 8'h00;
    for (int m = 1; m < 3; m++) begin
      // A frame flag left over from the pass before would make the next mode read busy.
      frameSet <= 1'h0;
      wr(ADDR_CTRL, 8'(m));
      settle(3, 8'h00);
      carrierSet <= 1'h1;
      settle(3, 8'(m == 1));
      carrierSet <= 1'h0;
      frameSet <= 1'h1;
      settle(3, 8'(m == 2));
    end
    n = startCnt;
    pulseSend();
    repeat (20) @(posedge clk);
    chk(8'(startCnt - n), 8'h00);
    frameSet <= 1'h0;
    repeat (5) @(posedge clk);
    chk(8'(startCnt - n), 8'h01);
    rd(ADDR_STATUS, d);
    chk(d, 8'h0C);
    wr(ADDR_STATUS, 8'h0C);
    rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    frameSet <= 1'h1;
    wr(ADDR_CTRL, 8'h0A);
    settle(3, 8'h00);
    pulseSend();
    repeat (5) @(posedge clk);
    chk(8'(startCnt - n), 8'h02);
    wr(ADDR_CTRL, 8'h03);
    carrierSet <= 1'h1;
    settle(3, 8'h00);
    carrierSet <= 1'h0;
    frameSet <= 1'h0;
    gainSet <= 8'hFF;
  endtask : testDetect
  // A very low start level makes any mixed window stay idle, so the rise
  // to busy cannot come before one whole window of new samples.
  task automatic testEnergy(input logic [2:0] code);
    int win;
    int n;
    logic [7:0] d;
    win = 10 << ((code > 3'h3) ? 4 : int'(code));
    gainSet <= 8'hFF;
    wr(ADDR_CTRL, {1'h0, code, 4'h0});
    waitBusy(1'h0, 400, n);
    gainSet <= 8'h4E;
    waitBusy(1'h1, 1000, n);
    chk(8'(n >= win - 10 && n <= 2 * win + 10), 8'h01);
    rd(ADDR_LEVEL, d);
    chk(d, 8'hB2);
    gainSet <= 8'h51;
    waitBusy(1'h0, 2 * win + 20, n);
    chk(8'(channelBusy_ff), 8'h01);
    gainSet <= 8'h53;
    waitBusy(1'h0, 2 * win + 20, n);
    chk(8'(channelBusy_ff), 8'h00);
  endtask : testEnergy
  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'h0;
    regAddr = 16'h0000;
    regWrData = 8'h00;
    regWr = 1'h0;
    regRd = 1'h0;
    gainSet = 8'hFF;
    carrierSet = 1'h0;
    frameSet = 1'h0;
    sendReq = 1'h0;
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    testRegs();
    testDetect();
    testEnergy(3'h0);
    testEnergy(3'h3);
    testEnergy(3'h5);
    reportAndStop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    reportAndStop();
  end
endmodule : cca_core_tb
bind cca_core cca_checker cca_checker_inst (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff),
  .frontEndGain(frontEndGain), .demod(demod), .txRequest(txRequest),
  .txStart_ff(txStart_ff), .channelBusy_ff(channelBusy_ff),
  .rssiAverageWindow_ff(rssiAverageWindow_ff));
